// ===== logic/lsec_ctrl.sv
// How it works
// - controller enable ticks every 2*(predivider+4) conversion clocks
// - manual, surveillance, auto modes; manual delays come only from register writes
// - surveillance repeatedly measures both eye edges and filters the centre
// - surveillance: filtered error above threshold raises flag and stops
// - interrupt register: enables at bits 3,2 and one flag at bit 7; bit 6 reads zero
// - enabled and raised flag drives the interrupt request pin
// - flag clears only after its enable was low for a controller cycle
// - auto mode loads the new optimal delay instead of stopping
// - data bits are latched by the delayed data sample strobe
// - a stopped data clock leaves the last two captured words held
// - check strobe samples the delayed clock copy to locate the window
// - sample delay bits 7:4; setup probe 7:4, hold probe 3:0
// - check strobe starts at sample delay, setup earlier, hold later
// - check result readable at bit 0, one means correct data cycle
// - each delay step is a fixed 80 ps, not a clock fraction
// - bit 7 runs surveillance, bits 7 and 6 together run auto
// - drift is flagged beyond the two-bit threshold in bits 1:0
// - filter adds centre change divided by 2^length, length capped at 12
`timescale 1ns/10ps
`default_nettype none
`include "lsec_regs.svh"

module lsec_ctrl #(
	parameter int DATA_W = 14
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	input wire logic check_sample,
	input wire logic data_sample_strobe,
	input wire logic [DATA_W-1:0] lvds_data_bits,
	output logic [DATA_W-1:0] dac_word1,
	output logic [DATA_W-1:0] dac_word2,
	output logic [3:0] sample_delay_setting,
	output logic [3:0] setup_probe_delay,
	output logic [3:0] hold_probe_delay,
	output logic ctrl_tick,
	output logic irq_req
);
	import lsec_pkg::*;

	function automatic logic [5:0] div_limit(input lsec_code_t ccd);
		div_limit = 6'((6'(ccd) + `LSEC_DIV_OFFSET) << 1) - 6'h01;
	endfunction

	function automatic lsec_code_t flt_len(input lsec_code_t f);
		flt_len = (f > `LSEC_FLT_MAX) ? `LSEC_FLT_MAX : f;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// controller clock divider
	logic [5:0] div_q, div_d;
	logic ctrl_en;
	lsec_code_t ccd_q;

	always_comb begin
		ctrl_en = (div_q >= div_limit(ccd_q));
		div_d = ctrl_en ? 6'h00 : div_q + 6'h01;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_d;
		end
	end

	assign ctrl_tick = ctrl_en;

	////////////////////////////////////////////////////////////////////////
	// data capture: even and odd words alternate between two holding registers
	logic [DATA_W-1:0] w1_q, w1_d, w2_q, w2_d;
	logic sel_q, sel_d;

	always_comb begin
		w1_d = w1_q;
		w2_d = w2_q;
		sel_d = sel_q;
		if (data_sample_strobe) begin
			if (!sel_q) begin
				w1_d = lvds_data_bits;
			end else begin
				w2_d = lvds_data_bits;
			end
			sel_d = !sel_q;
		end
		// no strobe: both words simply hold, the converter keeps replaying them
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			w1_q <= '0;
			w2_q <= '0;
			sel_q <= 1'b0;
		end else begin
			w1_q <= w1_d;
			w2_q <= w2_d;
			sel_q <= sel_d;
		end
	end

	assign dac_word1 = w1_q;
	assign dac_word2 = w2_q;

	////////////////////////////////////////////////////////////////////////
	// registers and eye controller
	logic [7:0] probe_q, probe_d, mode_q, mode_d, mode_s_q, mode_s_d;
	lsec_code_t sd_q, sd_d, ccd_d, cnt_q, cnt_d, msd_q, msd_d;
	lsec_code_t o_sd_q, o_sd_d, o_su_q, o_su_d, o_ho_q, o_ho_d;
	logic en3_q, en3_d, en2_q, en2_d, en3_s_q, en3_s_d, flag_q, flag_d;
	logic check_q, check_d;
	lsec_state_t st_q, st_d;
	lsec_avg_t avg_q, avg_d;
	lsec_avg_t meas, delta;
	logic signed [5:0] err;
	logic signed [5:0] sd_sum;
	logic [5:0] err_abs;
	logic trip, watch, auto_on;

	always_comb begin
		probe_d = probe_q;
		mode_d = mode_q;
		sd_d = sd_q;
		ccd_d = ccd_q;
		en3_d = en3_q;
		en2_d = en2_q;
		mode_s_d = mode_s_q;
		en3_s_d = en3_s_q;
		flag_d = flag_q;
		check_d = check_q;
		st_d = st_q;
		cnt_d = cnt_q;
		msd_d = msd_q;
		avg_d = avg_q;
		watch = mode_s_q[`LSEC_MODE_WATCH];
		auto_on = watch && mode_s_q[`LSEC_MODE_AUTO];
		meas = lsec_avg_t'($signed({2'b00, cnt_q}) - $signed({2'b00, msd_q})) <<< `LSEC_FRAC_BITS;
		delta = meas - avg_q;
		// centre in whole steps is avg/2 with the fraction dropped
		err = 6'(avg_q >>> (`LSEC_FRAC_BITS + 1));
		err_abs = err[5] ? 6'(-err) : err;
		trip = err_abs > {4'h0, mode_s_q[`LSEC_THR_HI:`LSEC_THR_LO]};
		sd_sum = $signed({2'b00, sd_q}) + err;
		if (reg_wr) begin
			unique case (reg_addr)
				`LSEC_ADDR_INT: begin
					en3_d = reg_wdata[`LSEC_INT_EN_LVDS];
					en2_d = reg_wdata[`LSEC_INT_EN_SYNC];
				end
				`LSEC_ADDR_PROBE: probe_d = reg_wdata;
				`LSEC_ADDR_SAMPLE: sd_d = reg_wdata[`LSEC_SD_HI:`LSEC_SD_LO];
				`LSEC_ADDR_MODE: mode_d = reg_wdata;
				`LSEC_ADDR_CLKDIV: ccd_d = reg_wdata[3:0];
				default: ;
			endcase
		end
		if (ctrl_en) begin
			// fields are re-sampled only at the tick so a half-written
			// setting never steers a measurement step
			mode_s_d = mode_q;
			en3_s_d = en3_q;
			check_d = check_sample;
			if (!en3_s_q) begin
				flag_d = 1'b0;
			end
			unique case (st_q)
				ST_IDLE: begin
					cnt_d = 4'h0;
					if (watch) begin
						st_d = ST_SETUP;
					end
				end
				ST_SETUP: begin
					// decide on the live check result: the probe code has stood for a
					// whole tick, while check_q may still hold the other sweep's probe
					if (!check_sample || cnt_q == 4'hF) begin
						msd_d = cnt_q;
						cnt_d = 4'h0;
						st_d = ST_HOLD;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				ST_HOLD: begin
					if (!check_sample || cnt_q == 4'hF) begin
						avg_d = avg_q + (delta >>> flt_len(mode_s_q[`LSEC_FLT_HI:`LSEC_FLT_LO]));
						st_d = ST_EVAL;
					end else begin
						cnt_d = cnt_q + 4'h1;
					end
				end
				ST_EVAL: begin
					st_d = ST_IDLE;
					if (trip) begin
						if (auto_on) begin
							if (!(reg_wr && reg_addr == `LSEC_ADDR_SAMPLE)) begin
								sd_d = sd_sum[5] ? 4'h0 : (sd_sum > 6'sd15 ? 4'hF : sd_sum[3:0]);
							end
							avg_d = '0;
						end else begin
							flag_d = 1'b1;
							st_d = ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (!watch) begin
						st_d = ST_IDLE;
						avg_d = '0;
					end
				end
			endcase
			if (!watch && st_q != ST_STOP) begin
				st_d = ST_IDLE;
				avg_d = '0;
			end
		end
		o_sd_d = sd_q;
		if (!watch || st_q == ST_IDLE || st_q == ST_STOP) begin
			o_su_d = probe_q[`LSEC_SETUP_HI:`LSEC_SETUP_LO];
			o_ho_d = probe_q[`LSEC_HOLD_HI:`LSEC_HOLD_LO];
		end else begin
			// one probe swept while the other sits at zero
			o_su_d = (st_q == ST_SETUP) ? cnt_q : 4'h0;
			o_ho_d = (st_q == ST_HOLD) ? cnt_q : 4'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			probe_q <= `LSEC_RST_BYTE;
			mode_q <= `LSEC_RST_BYTE;
			mode_s_q <= `LSEC_RST_BYTE;
			sd_q <= `LSEC_RST_NIBBLE;
			ccd_q <= `LSEC_RST_NIBBLE;
			en3_q <= 1'b0;
			en2_q <= 1'b0;
			en3_s_q <= 1'b0;
			flag_q <= 1'b0;
			check_q <= 1'b0;
			st_q <= ST_IDLE;
			cnt_q <= 4'h0;
			msd_q <= 4'h0;
			avg_q <= '0;
			o_sd_q <= 4'h0;
			o_su_q <= 4'h0;
			o_ho_q <= 4'h0;
		end else begin
			probe_q <= probe_d;
			mode_q <= mode_d;
			mode_s_q <= mode_s_d;
			sd_q <= sd_d;
			ccd_q <= ccd_d;
			en3_q <= en3_d;
			en2_q <= en2_d;
			en3_s_q <= en3_s_d;
			flag_q <= flag_d;
			check_q <= check_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			msd_q <= msd_d;
			avg_q <= avg_d;
			o_sd_q <= o_sd_d;
			o_su_q <= o_su_d;
			o_ho_q <= o_ho_d;
		end
	end

	// delay codes go to the analog delay lines in fixed 80 ps steps
	assign sample_delay_setting = o_sd_q;
	assign setup_probe_delay = o_su_q;
	assign hold_probe_delay = o_ho_q;
	assign irq_req = flag_q && en3_q;

	always_comb begin
		unique case (reg_addr)
			`LSEC_ADDR_INT: reg_rdata = {flag_q, 3'b000, en3_q, en2_q, 2'b00};
			`LSEC_ADDR_PROBE: reg_rdata = probe_q;
			`LSEC_ADDR_SAMPLE: reg_rdata = {sd_q, 3'b000, check_q};
			`LSEC_ADDR_MODE: reg_rdata = mode_q;
			`LSEC_ADDR_CLKDIV: reg_rdata = {4'h0, ccd_q};
			default: reg_rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_div_gap;
		ctrl_en |=> !ctrl_en [*7];
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("tick spacing too short");

	property p_irq_pin;
		$rose(flag_q) && en3_q |-> irq_req;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("irq pin missing");

	property p_flag_hold;
		flag_q && en3_s_q && !ctrl_en |=> flag_q;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared while enabled");

	property p_stop;
		ctrl_en && st_q == ST_EVAL && trip && !auto_on && watch |=> st_q == ST_STOP && flag_q;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop on threshold");

	property p_auto_quiet;
		$rose(flag_q) |-> !$past(auto_on);
	endproperty
	a_auto_quiet: assert property (p_auto_quiet) else $error("flag raised in auto");

	property p_manual_probe;
		!watch ##1 !watch |-> setup_probe_delay == $past(probe_q[7:4], 1);
	endproperty
	a_manual_probe: assert property (p_manual_probe) else $error("manual probe mismatch");

	property p_check;
		ctrl_en |=> check_q == $past(check_sample);
	endproperty
	a_check: assert property (p_check) else $error("check bit not captured");

	sequence s_first_word;
		data_sample_strobe && !sel_q;
	endsequence
	property p_capture;
		s_first_word |=> dac_word1 == $past(lvds_data_bits) ##0 sel_q;
	endproperty
	a_capture: assert property (p_capture) else $error("word not captured");

	property p_hold_words;
		!data_sample_strobe |=> $stable(dac_word1) && $stable(dac_word2);
	endproperty
	a_hold_words: assert property (p_hold_words) else $error("words moved without strobe");

endmodule // lsec_ctrl
`default_nettype wire

// ===== logic/lsec_regs.svh
`ifndef LSEC_REGS_SVH
`define LSEC_REGS_SVH

// register offsets on the serial port's internal register bus
`define LSEC_ADDR_INT 5'h01
`define LSEC_ADDR_PROBE 5'h04
`define LSEC_ADDR_SAMPLE 5'h05
`define LSEC_ADDR_MODE 5'h06
`define LSEC_ADDR_CLKDIV 5'h16

// interrupt_control_flags fields
`define LSEC_INT_EN_LVDS 3
`define LSEC_INT_EN_SYNC 2
`define LSEC_INT_FLAG_LVDS 7
`define LSEC_INT_FLAG_SYNC 6

// probe_delay_settings and sample_delay_and_check fields
`define LSEC_SETUP_HI 7
`define LSEC_SETUP_LO 4
`define LSEC_HOLD_HI 3
`define LSEC_HOLD_LO 0
`define LSEC_SD_HI 7
`define LSEC_SD_LO 4
`define LSEC_CHECK_BIT 0

// mode register fields
`define LSEC_MODE_WATCH 7
`define LSEC_MODE_AUTO 6
`define LSEC_FLT_HI 5
`define LSEC_FLT_LO 2
`define LSEC_THR_HI 1
`define LSEC_THR_LO 0

// controller clock divider: ratio 2*(field + offset)
`define LSEC_DIV_OFFSET 6'h04
`define LSEC_FLT_MAX 4'hC
`define LSEC_FRAC_BITS 12
`define LSEC_STEP_PS 80

// reset values
`define LSEC_RST_BYTE 8'h00
`define LSEC_RST_NIBBLE 4'h0

`endif

// ===== logic/lsec_pkg.sv
package lsec_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_HOLD,
		ST_EVAL,
		ST_STOP
	} lsec_state_t;
	typedef logic [3:0] lsec_code_t;
	typedef logic signed [17:0] lsec_avg_t;
endpackage

// ===== testbench/lsec_src.sv
`timescale 1ns/10ps
`default_nettype none
module lsec_src (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic run,
	input wire logic [4:0] lead,
	input wire logic [4:0] trail,
	input wire logic [3:0] sd,
	input wire logic [3:0] setup,
	input wire logic [3:0] hold,
	output logic check_sample,
	output logic strobe,
	output logic [13:0] data
);
	int seed = 85;
	int p;
	logic ph;
	initial begin
		check_sample = 1'b0;
		strobe = 1'b0;
		data = 14'h0000;
		ph = 1'b0;
	end
	always @(posedge mclk) begin
		// eye spans lead steps before and trail steps after the nominal point
		p = int'(sd) - int'(setup) + int'(hold);
		check_sample <= (p > -int'(lead)) && (p < int'(trail));
		// clock sent like a data bit toggling 0101, one latching edge per two cycles
		ph <= run ? ~ph : 1'b0;
		strobe <= run && resetn && ph;
		// off-strobe the lines carry garbage so a held word is really held
		data <= (run && ph) ? 14'($random(seed)) : ~data;
	end
endmodule // lsec_src
`default_nettype wire

// ===== testbench/lvds_sample_eye_controller_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lvds_sample_eye_controller_tb;
	logic mclk, resetn, reg_wr, run, cs, stb, tick, irq, odd;
	logic [4:0] reg_addr, lead, trail;
	logic [7:0] reg_wdata, reg_rdata, v, r8, ms, mh;
	logic [13:0] data, w1, w2, e1, e2;
	logic [3:0] sd, su, ho;
	logic [4:0] adr [6] = '{5'h01, 5'h04, 5'h05, 5'h06, 5'h16, 5'h02};
	int err_total = 0;
	int checked = 0;
	int seed = 85;
	int n, k;
	lsec_ctrl i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .check_sample(cs),
		.data_sample_strobe(stb), .lvds_data_bits(data), .dac_word1(w1), .dac_word2(w2),
		.sample_delay_setting(sd), .setup_probe_delay(su), .hold_probe_delay(ho),
		.ctrl_tick(tick), .irq_req(irq));
	lsec_src i_src (.mclk(mclk), .resetn(resetn), .run(run), .lead(lead), .trail(trail),
		.sd(sd), .setup(su), .hold(ho), .check_sample(cs), .strobe(stb), .data(data));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_word(input logic [13:0] got, input logic [13:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	// returns at the negedge showing a tick; n+1 is then the spacing of the last two
	task automatic ticks(input int t);
		repeat (t) begin
			n = 0;
			@(negedge mclk);
			while (tick !== 1'b1 && n < 100) begin
				@(negedge mclk);
				n++;
			end
		end
	endtask
	// probe codes settle a cycle after the write but get sampled only on controller ticks, so wait two
	task automatic search(input logic hold_side, output logic [7:0] r);
		for (k = 0; k < 16; k++) begin
			wr(5'h04, hold_side ? 8'(k) : 8'(k << 4));
			ticks(2);
			rd(5'h05, v);
			if (v[0] === 1'b0) break;
		end
		r = 8'(k);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		if (!resetn) begin
			e1 = 14'h0000;
			e2 = 14'h0000;
			odd = 1'b0;
		end else begin
			chk_word(w1, e1, "word1");
			chk_word(w2, e2, "word2");
			if (stb) begin
				if (odd) begin
					e2 = data;
				end else begin
					e1 = data;
				end
				odd = ~odd;
			end
		end
	end
	initial begin
		repeat (30000) @(posedge mclk);
		err_total++;
		wrap_up();
	end
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		run = 1'b1;
		lead = 5'h05;
		trail = 5'h0D;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		foreach (adr[i]) begin
			rd(adr[i], r8);
			chk_reg(r8, 8'h00, "reset value");
		end
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'($random(seed) & 15);
			wr(5'h16, v);
			ticks(2);
			chk_reg(8'(n + 1), 8'(2 * (v + 4)), "tick period");
		end
		wr(5'h16, 8'h00);
		repeat (4) begin
			v = 8'($random(seed));
			wr(5'h04, v);
			rd(5'h04, r8);
			chk_reg(r8, v, "probe reg");
			chk_reg({su, ho}, v, "probe out");
		end
		wr(5'h04, 8'h00);
		wr(5'h05, 8'hF1);
		wr(5'h02, 8'hFF);
		ticks(2);
		rd(5'h05, r8);
		chk_reg(r8, 8'hF0, "late check");
		rd(5'h02, r8);
		chk_reg(r8, 8'h00, "unmapped");
		wr(5'h05, 8'h00);
		search(1'b0, ms);
		chk_reg(ms, 8'h05, "lead edge");
		search(1'b1, mh);
		chk_reg(mh, 8'h0D, "trail edge");
		v = (mh - ms) >> 1;
		wr(5'h05, {v[3:0], 4'h0});
		// the delay code pin is registered one cycle behind the register
		@(posedge mclk);
		@(negedge mclk);
		chk_reg({4'h0, sd}, 8'h04, "sample delay");
		search(1'b0, ms);
		search(1'b1, mh);
		chk_reg(ms, 8'h09, "recheck lead");
		chk_reg(mh, 8'h09, "recheck trail");
		wr(5'h04, 8'h00);
		////////////////////////////////////////////////////////////////////////
		wr(5'h01, 8'h0C);
		rd(5'h01, r8);
		chk_reg(r8, 8'h0C, "enables");
		wr(5'h06, 8'h80);
		repeat (800) @(posedge mclk);
		rd(5'h01, r8);
		chk_reg(r8, 8'h0C, "centred");
		wr(5'h06, 8'h82);
		lead <= 5'h03;
		trail <= 5'h0F;
		repeat (800) @(posedge mclk);
		rd(5'h01, r8);
		chk_reg(r8, 8'h0C, "at threshold");
		wr(5'h06, 8'h81);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		chk_reg({7'h00, irq}, 8'h01, "irq");
		rd(5'h01, r8);
		chk_reg(r8, 8'h8C, "flag");
		repeat (400) @(posedge mclk);
		chk_reg({4'h0, sd}, 8'h04, "stopped");
		wr(5'h01, 8'h04);
		@(negedge mclk);
		chk_reg({7'h00, irq}, 8'h00, "gated");
		ticks(3);
		rd(5'h01, r8);
		chk_reg(r8, 8'h04, "flag clear");
		wr(5'h01, 8'h08);
		wr(5'h06, 8'h00);
		repeat (100) @(posedge mclk);
		chk_reg({7'h00, irq}, 8'h00, "stays clear");
		////////////////////////////////////////////////////////////////////////
		lead <= 5'h05;
		trail <= 5'h0D;
		wr(5'h05, 8'h40);
		wr(5'h01, 8'h00);
		wr(5'h06, 8'hC0);
		repeat (800) @(posedge mclk);
		chk_reg({4'h0, sd}, 8'h04, "auto idle");
		lead <= 5'h03;
		trail <= 5'h0F;
		n = 0;
		while (sd !== 4'h6 && n < 3000) begin
			@(negedge mclk);
			n++;
		end
		repeat (800) @(posedge mclk);
		chk_reg({4'h0, sd}, 8'h06, "auto update");
		rd(5'h01, r8);
		chk_reg(r8, 8'h00, "no flag");
		run <= 1'b0;
		repeat (100) @(posedge mclk);
		wrap_up();
	end
endmodule // lvds_sample_eye_controller_tb
`default_nettype wire
